// ### logic/spexr_pkg.sv
// Constants, carrier types and state layout of the serial parameter exception responder
// Overview of operation
// [RULE1] Link integer equals value times ten power decimals
// [RULE2] Accepted write divided by scale before storing
// [RULE3] Successful request echoes function code unchanged
// [RULE4] Failed request returns function code with MSB set
// [RULE5] Exception response adds one cause code byte
// [RULE6] Cause 01H: unimplemented function or fault state
// [RULE7] Cause 02H: address or address-length combination invalid
// [RULE8] Cause 03H: request data field value not permitted
// [RULE9] Cause 04H: written value invalid or conflicting
// [RULE10] Cause 05H: password verification value mismatch
// [RULE11] Cause 06H: wrong frame length or CRC mismatch
// [RULE12] Cause 07H: write to read-only parameter, unchanged
// [RULE13] Cause 08H: run-locked parameter written while running
// [RULE14] Cause 09H: locked by password, reject reads/writes
// [RULE15] Master retries or corrects after exception
// [RULE16] Successful single write echoes whole received frame
// [RULE17] Exception frame: address, code, cause, CRC
// [RULE18] One cause by fixed priority, frame first
package spexr_pkg;

  // ==========================================================
  // Function and cause codes
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] BROADCAST_ADDR = 8'h00;
  localparam logic [7:0] CAUSE_NONE = 8'h00;
  localparam logic [7:0] CAUSE_BAD_CMD = 8'h01;
  localparam logic [7:0] CAUSE_BAD_ADDR = 8'h02;
  localparam logic [7:0] CAUSE_BAD_DATA = 8'h03;
  localparam logic [7:0] CAUSE_OP_FAIL = 8'h04;
  localparam logic [7:0] CAUSE_PWD_ERR = 8'h05;
  localparam logic [7:0] CAUSE_FRAME = 8'h06;
  localparam logic [7:0] CAUSE_READ_ONLY = 8'h07;
  localparam logic [7:0] CAUSE_RUN_LOCK = 8'h08;
  localparam logic [7:0] CAUSE_LOCKED = 8'h09;

  // ==========================================================
  // Frame layout
  localparam logic [3:0] BUF_BYTES = 4'h8;
  localparam logic [3:0] FRAME_LEN = 4'h8;
  localparam logic [3:0] MIN_FRAME = 4'h4;
  localparam logic [3:0] CRC_BYTES = 4'h2;
  localparam logic [3:0] EXC_LEN = 4'h3;
  localparam logic [3:0] RD_LEN = 4'h5;
  localparam int POS_ADDR = 0;
  localparam int POS_FUNC = 1;
  localparam int POS_REG_HI = 2;
  localparam int POS_REG_LO = 3;
  localparam int POS_DAT_HI = 4;
  localparam int POS_DAT_LO = 5;
  localparam logic [7:0] RD_BYTE_CNT = 8'h02;
  localparam logic [15:0] RD_QTY_ONE = 16'h0001;
  localparam logic [15:0] RD_QTY_ZERO = 16'h0000;

  // ==========================================================
  // CRC and fieldbus scale
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam logic [15:0] SCALE_DEC0 = 16'h0001; // RULE1
  localparam logic [15:0] SCALE_DEC1 = 16'h000a; // RULE1
  localparam logic [15:0] SCALE_DEC2 = 16'h0064; // RULE1
  localparam logic [15:0] SCALE_DEC3 = 16'h03e8; // RULE1

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_RX = 2'b00,
    ST_EVAL = 2'b01,
    ST_SEND = 2'b10
  } spexr_state_type;

  typedef struct packed {
    logic exists;
    logic readonly;
    logic run_locked;
    logic conflict;
    logic [1:0] decimals;
    logic [15:0] min_val;
    logic [15:0] max_val;
    logic [15:0] rd_whole;
    logic [9:0] rd_frac;
  } spexr_attr_type;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [15:0] whole;
    logic [9:0] frac;
  } spexr_wr_type;

  typedef struct packed {
    spexr_state_type st;
    logic [7:0][7:0] rx_buf;
    logic [3:0] rx_cnt;
    logic rx_over;
    logic [15:0] rx_crc;
    logic unlocked;
    logic [7:0][7:0] tx_buf;
    logic [3:0] tx_len;
    logic tx_raw;
    logic [3:0] tx_idx;
    logic [15:0] tx_crc;
    logic [7:0] tx_byte;
    logic [7:0] cause;
    spexr_wr_type wr;
  } spexr_regs_type;

endpackage : spexr_pkg

// ### logic/spexr_crc_byte.sv
// One-byte update of the reflected CRC-16 used on the serial parameter link
module spexr_crc_byte (
  input wire logic [15:0] crc_in,
  input wire logic [7:0] byte_in,
  output logic [15:0] crc_out
);

  logic [15:0] acc;

  always_comb begin
    acc = crc_in ^ {8'h00, byte_in};
    for (int i = 0; i < 8; i++) begin
      if (acc[0]) begin
        acc = (acc >> 1) ^ spexr_pkg::CRC_POLY;
      end else begin
        acc = acc >> 1;
      end
    end
    crc_out = acc;
  end

endmodule : spexr_crc_byte

// ### logic/spexr_responder.sv
// Request checker and normal/exception response builder for the serial parameter link
module spexr_responder #(
  parameter logic [15:0] PWD_VERIFY_ADDR = 16'h0000
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [7:0] slave_addr_in,
  input wire logic fault_state_in,
  input wire logic running_in,
  input wire logic password_set_in,
  input wire logic [15:0] user_password_setting_in,
  input wire logic password_lock_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_end_in,
  output logic rx_ready_out,
  output logic [15:0] param_addr_out,
  output logic [15:0] param_wdata_out,
  input wire spexr_pkg::spexr_attr_type param_attr_in,
  output spexr_pkg::spexr_wr_type param_wr_out,
  output logic unlocked_out,
  output logic [7:0] resp_cause_out,
  output logic tx_valid_out,
  output logic [7:0] tx_byte_out,
  output logic tx_last_out,
  input wire logic tx_ready_in
);

  spexr_pkg::spexr_regs_type r;
  spexr_pkg::spexr_regs_type n;

  // ==========================================================
  // CRC engines
  logic [15:0] rx_crc_upd;
  logic [15:0] tx_crc_upd;

  spexr_crc_byte u_rx_crc (
    .crc_in(r.rx_crc),
    .byte_in(rx_byte_in),
    .crc_out(rx_crc_upd)
  );

  spexr_crc_byte u_tx_crc (
    .crc_in(r.tx_crc),
    .byte_in(r.tx_byte),
    .crc_out(tx_crc_upd)
  );

  // ==========================================================
  // Request fields
  logic [7:0] func;
  logic [15:0] reg_addr;
  logic [15:0] data_word;

  assign func = r.rx_buf[spexr_pkg::POS_FUNC];
  assign reg_addr = {r.rx_buf[spexr_pkg::POS_REG_HI], r.rx_buf[spexr_pkg::POS_REG_LO]};
  assign data_word = {r.rx_buf[spexr_pkg::POS_DAT_HI], r.rx_buf[spexr_pkg::POS_DAT_LO]};

  // ==========================================================
  // Fieldbus scale
  logic [15:0] scale;
  logic [15:0] quot;
  logic [15:0] rem;
  logic [31:0] scaled;
  logic [15:0] rd_value;

  always_comb begin
    unique case (param_attr_in.decimals)
      2'h0: scale = spexr_pkg::SCALE_DEC0; // RULE1
      2'h1: scale = spexr_pkg::SCALE_DEC1; // RULE1
      2'h2: scale = spexr_pkg::SCALE_DEC2; // RULE1
      2'h3: scale = spexr_pkg::SCALE_DEC3; // RULE1
    endcase
  end

  // Constant divisors only; the divider stays small enough for one cycle
  assign quot = data_word / scale; // RULE2
  assign rem = data_word % scale; // RULE2
  assign scaled = param_attr_in.rd_whole * scale; // RULE1
  assign rd_value = scaled[15:0] + {6'h00, param_attr_in.rd_frac}; // RULE1

  // ==========================================================
  // Request classification
  logic is_impl;
  logic is_bcast;
  logic addressed;
  logic frame_bad;
  logic pwd_write;
  logic [7:0] cause;

  assign is_impl = (func == spexr_pkg::FC_READ) || (func == spexr_pkg::FC_WRITE);
  assign is_bcast = r.rx_buf[spexr_pkg::POS_ADDR] == spexr_pkg::BROADCAST_ADDR;
  // Two bytes at least are needed to have a function code to answer with
  assign addressed = (r.rx_cnt >= 4'h2) && (is_bcast || (r.rx_buf[spexr_pkg::POS_ADDR] == slave_addr_in));
  assign frame_bad = r.rx_over || (r.rx_cnt < spexr_pkg::MIN_FRAME) ||
                     (r.rx_crc != spexr_pkg::CRC_RESIDUE) ||
                     (is_impl && (r.rx_cnt != spexr_pkg::FRAME_LEN)); // RULE11
  // The unlock write itself must pass the lock, or the device could never be opened
  assign pwd_write = (func == spexr_pkg::FC_WRITE) && (reg_addr == PWD_VERIFY_ADDR);

  always_comb begin
    cause = spexr_pkg::CAUSE_NONE;
    if (frame_bad) begin // RULE18
      cause = spexr_pkg::CAUSE_FRAME; // RULE11
    end else if (!is_impl || fault_state_in) begin
      cause = spexr_pkg::CAUSE_BAD_CMD; // RULE6
    end else if (pwd_write) begin
      if (data_word != user_password_setting_in) begin
        cause = spexr_pkg::CAUSE_PWD_ERR; // RULE10
      end
    end else if (password_set_in && !r.unlocked) begin
      cause = spexr_pkg::CAUSE_LOCKED; // RULE14
    end else if (func == spexr_pkg::FC_READ) begin
      if (data_word == spexr_pkg::RD_QTY_ZERO) begin
        cause = spexr_pkg::CAUSE_BAD_DATA; // RULE8
      end else if (!param_attr_in.exists || (data_word != spexr_pkg::RD_QTY_ONE)) begin
        cause = spexr_pkg::CAUSE_BAD_ADDR; // RULE7
      end
    end else begin
      if (!param_attr_in.exists) begin
        cause = spexr_pkg::CAUSE_BAD_ADDR; // RULE7
      end else if (param_attr_in.readonly) begin
        cause = spexr_pkg::CAUSE_READ_ONLY; // RULE12
      end else if (param_attr_in.run_locked && running_in) begin
        cause = spexr_pkg::CAUSE_RUN_LOCK; // RULE13
      end else if ((data_word < param_attr_in.min_val) || (data_word > param_attr_in.max_val) ||
                   param_attr_in.conflict) begin
        cause = spexr_pkg::CAUSE_OP_FAIL; // RULE9
      end
    end
  end

  // ==========================================================
  // Response frame contents
  logic [7:0][7:0] resp_buf;
  logic [3:0] resp_len;
  logic resp_raw;

  always_comb begin
    resp_buf = r.rx_buf;
    resp_len = spexr_pkg::FRAME_LEN;
    resp_raw = 1'b1;
    if (cause != spexr_pkg::CAUSE_NONE) begin
      resp_buf = '0;
      resp_buf[0] = r.rx_buf[spexr_pkg::POS_ADDR]; // RULE17
      resp_buf[1] = func | spexr_pkg::EXC_FLAG; // RULE4
      resp_buf[2] = cause; // RULE5
      resp_len = spexr_pkg::EXC_LEN; // RULE17
      resp_raw = 1'b0;
    end else if (func == spexr_pkg::FC_READ) begin
      resp_buf = '0;
      resp_buf[0] = r.rx_buf[spexr_pkg::POS_ADDR];
      resp_buf[1] = func; // RULE3
      resp_buf[2] = spexr_pkg::RD_BYTE_CNT;
      resp_buf[3] = rd_value[15:8];
      resp_buf[4] = rd_value[7:0];
      resp_len = spexr_pkg::RD_LEN;
      resp_raw = 1'b0;
    end
  end

  // ==========================================================
  // Transmit sequencing
  logic [3:0] tx_total;
  logic tx_last;
  logic [3:0] tx_next_idx;

  // An echoed frame already holds its CRC, so nothing is appended to it
  assign tx_total = r.tx_raw ? r.tx_len : (r.tx_len + spexr_pkg::CRC_BYTES);
  assign tx_last = r.tx_idx == (tx_total - 4'h1);
  assign tx_next_idx = r.tx_idx + 4'h1;

  // ==========================================================
  // Next state
  always_comb begin
    n = r;
    n.wr.valid = 1'b0;
    if (password_lock_in) begin
      n.unlocked = 1'b0;
    end
    unique case (r.st)
      spexr_pkg::ST_RX: begin
        if (rx_valid_in) begin
          n.rx_crc = rx_crc_upd;
          if (r.rx_cnt < spexr_pkg::BUF_BYTES) begin
            n.rx_buf[r.rx_cnt[2:0]] = rx_byte_in;
            n.rx_cnt = r.rx_cnt + 4'h1;
          end else begin
            n.rx_over = 1'b1; // RULE11
          end
        end
        if (rx_end_in && (rx_valid_in || (r.rx_cnt != 4'h0))) begin
          n.st = spexr_pkg::ST_EVAL;
        end
      end
      spexr_pkg::ST_EVAL: begin
        n.rx_cnt = 4'h0;
        n.rx_over = 1'b0;
        n.rx_crc = spexr_pkg::CRC_INIT;
        n.st = spexr_pkg::ST_RX;
        if (addressed) begin
          n.cause = cause;
          if (cause == spexr_pkg::CAUSE_NONE && func == spexr_pkg::FC_WRITE) begin
            if (pwd_write) begin
              n.unlocked = 1'b1; // RULE10
            end else begin
              n.wr.valid = 1'b1; // RULE2
              n.wr.addr = reg_addr;
              n.wr.whole = quot; // RULE2
              n.wr.frac = rem[9:0]; // RULE2
            end
          end
          // Broadcast requests are acted on silently
          if (!is_bcast) begin
            n.tx_buf = resp_buf; // RULE16
            n.tx_len = resp_len;
            n.tx_raw = resp_raw; // RULE16
            n.tx_idx = 4'h0;
            n.tx_crc = spexr_pkg::CRC_INIT;
            n.tx_byte = resp_buf[0];
            n.st = spexr_pkg::ST_SEND;
          end
        end
      end
      spexr_pkg::ST_SEND: begin
        if (tx_ready_in) begin
          if (tx_last) begin
            n.st = spexr_pkg::ST_RX;
          end else begin
            n.tx_idx = tx_next_idx;
            if (tx_next_idx < r.tx_len) begin
              n.tx_byte = r.tx_buf[tx_next_idx[2:0]];
            end else if (tx_next_idx == r.tx_len) begin
              n.tx_byte = tx_crc_upd[7:0]; // RULE17
            end else begin
              n.tx_byte = r.tx_crc[15:8]; // RULE17
            end
            if (r.tx_idx < r.tx_len) begin
              n.tx_crc = tx_crc_upd; // RULE17
            end
          end
        end
      end
      default: begin
        n.st = spexr_pkg::ST_RX;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      r <= '0;
      r.st <= spexr_pkg::ST_RX;
      r.rx_crc <= spexr_pkg::CRC_INIT;
      r.tx_crc <= spexr_pkg::CRC_INIT;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign rx_ready_out = r.st == spexr_pkg::ST_RX;
  assign param_addr_out = reg_addr;
  assign param_wdata_out = data_word;
  assign param_wr_out = r.wr;
  assign unlocked_out = r.unlocked;
  assign resp_cause_out = r.cause;
  assign tx_valid_out = r.st == spexr_pkg::ST_SEND;
  assign tx_byte_out = r.tx_byte;
  assign tx_last_out = (r.st == spexr_pkg::ST_SEND) && tx_last;

endmodule : spexr_responder

// ### dv/spexr_responder_props.sv
// Port checker for the serial parameter responder, bound to its top module
module spexr_responder_props (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic password_lock_in,
  input wire logic rx_ready_out,
  input wire spexr_pkg::spexr_attr_type param_attr_in,
  input wire logic [15:0] param_wdata_out,
  input wire spexr_pkg::spexr_wr_type param_wr_out,
  input wire logic unlocked_out,
  input wire logic [7:0] resp_cause_out,
  input wire logic tx_valid_out,
  input wire logic [7:0] tx_byte_out,
  input wire logic tx_last_out,
  input wire logic tx_ready_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] idx_r;
  function automatic logic [31:0] scl(input logic [1:0] d);
    case (d)
      2'h0: return 32'(spexr_pkg::SCALE_DEC0);
      2'h1: return 32'(spexr_pkg::SCALE_DEC1);
      2'h2: return 32'(spexr_pkg::SCALE_DEC2);
      default: return 32'(spexr_pkg::SCALE_DEC3);
    endcase
  endfunction : scl
  // ==========================================================
  // Byte position within the response
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      idx_r <= 4'h0;
    end else if (tx_valid_out && tx_ready_in) begin
      idx_r <= tx_last_out ? 4'h0 : idx_r + 4'h1;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  a_reset_idle: assert property (disable iff (1'b0) !resetn_in |=> !tx_valid_out && !param_wr_out.valid
    && !unlocked_out && resp_cause_out == 8'h00) else $error("outputs active after reset");
  a_exc_flag: assert property (tx_valid_out && idx_r == 4'h1 |-> tx_byte_out[7] == (resp_cause_out != 8'h00))
    else $error("function code flag wrong");
  a_cause_byte: assert property (tx_valid_out && idx_r == 4'h2 && resp_cause_out != 8'h00 |-> tx_byte_out == resp_cause_out)
    else $error("cause byte wrong");
  a_exc_len: assert property (tx_valid_out && tx_last_out && resp_cause_out != 8'h00 |-> idx_r == 4'h4)
    else $error("exception frame length wrong");
  a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out) && $stable(tx_last_out))
    else $error("stalled byte changed");
  a_rx_closed: assert property (tx_valid_out |-> !rx_ready_out)
    else $error("receiver open while sending");
  a_answer_time: assert property ($fell(rx_ready_out) |=> tx_valid_out || rx_ready_out)
    else $error("response late");
  a_wr_scale: assert property (param_wr_out.valid |-> 32'(param_wr_out.whole) * scl(param_attr_in.decimals)
    + 32'(param_wr_out.frac) == 32'(param_wdata_out)) else $error("scaled write wrong");
  a_wr_ok_only: assert property (param_wr_out.valid |-> resp_cause_out == 8'h00)
    else $error("failed write applied");
  a_relock: assert property (password_lock_in && rx_ready_out |=> !unlocked_out)
    else $error("relock ignored");
  c_exception: cover property (tx_valid_out && tx_last_out && tx_ready_in && resp_cause_out != 8'h00);
  c_write: cover property (param_wr_out.valid);
  c_stall: cover property (tx_valid_out && !tx_ready_in);
endmodule : spexr_responder_props

bind spexr_responder spexr_responder_props u_props (.mclk_in(mclk_in), .resetn_in(resetn_in),
  .password_lock_in(password_lock_in), .rx_ready_out(rx_ready_out), .param_attr_in(param_attr_in),
  .param_wdata_out(param_wdata_out), .param_wr_out(param_wr_out), .unlocked_out(unlocked_out),
  .resp_cause_out(resp_cause_out), .tx_valid_out(tx_valid_out), .tx_byte_out(tx_byte_out),
  .tx_last_out(tx_last_out), .tx_ready_in(tx_ready_in));

// ### dv/spexr_host.sv
// Bus master model: sends framed requests and gathers responses
module spexr_host (
  input wire logic mclk_in,
  input wire logic rx_ready_out,
  input wire logic tx_valid_out,
  input wire logic [7:0] tx_byte_out,
  input wire logic tx_last_out,
  output logic rx_valid_in,
  output logic [7:0] rx_byte_in,
  output logic rx_end_in,
  output logic tx_ready_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic slow = 1'b0;
  logic [1:0] cnt_r = 2'h0;
  logic [7:0] got[$];
  // Position of the byte that carried the last-byte mark, -1 when none came
  int last_at = -1;
  initial begin
    rx_valid_in = 1'b0;
    rx_byte_in = 8'h00;
    rx_end_in = 1'b0;
    tx_ready_in = 1'b1;
  end
  // Slow mode accepts one byte in four
  always @(negedge mclk_in) begin
    cnt_r <= cnt_r + 2'h1;
    tx_ready_in <= !slow || cnt_r == 2'h0;
  end
  always @(posedge mclk_in) begin
    if (tx_valid_out && tx_ready_in && tx_last_out) last_at = got.size();
    if (tx_valid_out && tx_ready_in) got.push_back(tx_byte_out);
  end
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = spexr_pkg::CRC_INIT;
    foreach (q[i]) begin
      c ^= 16'(q[i]);
      repeat (8) c = c[0] ? (c >> 1) ^ spexr_pkg::CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc16
  task automatic xfer(input logic [7:0] q[$], input logic bad, output logic [7:0] r[$]);
    logic [15:0] c;
    int n;
    c = crc16(q) ^ 16'(bad);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    n = 0;
    @(negedge mclk_in);
    while (!rx_ready_out && n < 300) begin
      @(negedge mclk_in);
      n++;
    end
    got = {};
    last_at = -1;
    foreach (q[i]) begin
      rx_valid_in = 1'b1;
      rx_byte_in = q[i];
      rx_end_in = (i == q.size() - 1);
      @(negedge mclk_in);
    end
    // Released data line must not keep showing the last byte
    rx_valid_in = 1'b0;
    rx_end_in = 1'b0;
    rx_byte_in = ~rx_byte_in;
    n = 0;
    while ((n < 3 || !rx_ready_out) && n < 400) begin
      @(negedge mclk_in);
      n++;
    end
    r = got;
  endtask : xfer
endmodule : spexr_host

// ### dv/spexr_responder_test.sv
// Self-checking bench for the serial parameter responder
module spexr_responder_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] PWD = 16'h0007;
  localparam logic [15:0] PWDV = 16'h2468;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic fault = 1'b0, running = 1'b0, pw_set = 1'b0, lock = 1'b0, unl = 1'b0;
  logic rx_valid, rx_end, rx_ready, unlocked, tx_valid, tx_last, tx_ready;
  logic [7:0] rx_byte, cause_seen, tx_byte;
  logic [15:0] p_addr, p_wdata;
  spexr_pkg::spexr_attr_type a = '0;
  spexr_pkg::spexr_wr_type wr;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int wr_pulses = 0;
  int p0;
  logic [7:0] rq[$];
  // Counted on the falling edge, where the registered pulse has settled
  always @(negedge mclk_in) if (wr.valid) wr_pulses++;
  always #4 mclk_in = ~mclk_in;
  spexr_responder #(.PWD_VERIFY_ADDR(PWD)) dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .slave_addr_in(8'h01),
    .fault_state_in(fault), .running_in(running), .password_set_in(pw_set), .user_password_setting_in(PWDV),
    .password_lock_in(lock), .rx_valid_in(rx_valid), .rx_byte_in(rx_byte), .rx_end_in(rx_end),
    .rx_ready_out(rx_ready), .param_addr_out(p_addr), .param_wdata_out(p_wdata), .param_attr_in(a),
    .param_wr_out(wr), .unlocked_out(unlocked), .resp_cause_out(cause_seen), .tx_valid_out(tx_valid),
    .tx_byte_out(tx_byte), .tx_last_out(tx_last), .tx_ready_in(tx_ready));
  spexr_host host (.mclk_in(mclk_in), .rx_ready_out(rx_ready), .tx_valid_out(tx_valid), .tx_byte_out(tx_byte),
    .tx_last_out(tx_last),
    .rx_valid_in(rx_valid), .rx_byte_in(rx_byte), .rx_end_in(rx_end), .tx_ready_in(tx_ready));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // Cut a hang short well above the expected run length
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [15:0] scl(input logic [1:0] d);
    return d == 2'h0 ? 16'h0001 : d == 2'h1 ? 16'h000a : d == 2'h2 ? 16'h0064 : 16'h03e8;
  endfunction : scl
  function automatic logic [7:0] cause_of(input logic [7:0] fn, input logic [15:0] ra, d, input int bad);
    if (bad != 0) return 8'h06;
    if (!(fn == 8'h03 || fn == 8'h06) || fault) return 8'h01;
    if (fn == 8'h06 && ra == PWD) return d == PWDV ? 8'h00 : 8'h05;
    if (pw_set && !unl) return 8'h09;
    if (fn == 8'h03) return d == 16'h0000 ? 8'h03 : (!a.exists || d != 16'h0001) ? 8'h02 : 8'h00;
    if (!a.exists) return 8'h02;
    if (a.readonly) return 8'h07;
    if (a.run_locked && running) return 8'h08;
    return (d < a.min_val || d > a.max_val || a.conflict) ? 8'h04 : 8'h00;
  endfunction : cause_of
  // ==========================================================
  // One request and its full expected response
  task automatic req(input logic [7:0] fn, input logic [15:0] ra, d, input int bad);
    logic [7:0] q[$], r[$], e[$], c;
    logic [15:0] v;
    int w0;
    c = cause_of(fn, ra, d, bad);
    q = {8'h01, fn, ra[15:8], ra[7:0], d[15:8], d[7:0]};
    if (bad == 2) void'(q.pop_back());
    v = 16'(32'(a.rd_whole) * 32'(scl(a.decimals)) + 32'(a.rd_frac));
    if (c != 8'h00) e = {8'h01, fn | 8'h80, c};
    else if (fn == 8'h06) e = q;
    else e = {8'h01, 8'h03, 8'h02, v[15:8], v[7:0]};
    w0 = wr_pulses;
    host.xfer(q, bad == 1, r);
    v = host.crc16(e);
    e.push_back(v[7:0]);
    e.push_back(v[15:8]);
    check("resp_len", 16'(r.size()), 16'(e.size()));
    foreach (e[i]) if (i < r.size()) check("resp_byte", 16'(r[i]), 16'(e[i]));
    check("cause", 16'(cause_seen), 16'(c));
    check("last_at", 16'(host.last_at), 16'(e.size() - 1));
    check("param_addr", p_addr, ra);
    if (bad != 2) check("param_wdata", p_wdata, d);
    if (fn == 8'h06 && c == 8'h00 && ra == PWD) unl = 1'b1;
    check("unlocked", 16'(unlocked), 16'(unl));
    check("wr_pulse", 16'(wr_pulses - w0), (fn == 8'h06 && c == 8'h00 && ra != PWD) ? 16'h0001 : 16'h0000);
    if (fn == 8'h06 && c == 8'h00 && ra != PWD) begin
      check("wr_addr", wr.addr, ra);
      check("wr_whole", wr.whole, d / scl(a.decimals));
      check("wr_frac", 16'(wr.frac), d % scl(a.decimals));
    end
  endtask : req
  task automatic relock();
    lock = 1'b1;
    @(negedge mclk_in);
    lock = 1'b0;
    unl = 1'b0;
  endtask : relock
  initial begin
    void'($urandom(32'h41016560));
    repeat (10) @(negedge mclk_in);
    resetn_in = 1'b1;
    // Setting range 0.0 to 3600.0 carried as tenths
    a.exists = 1'b1;
    a.decimals = 2'h1;
    a.max_val = 16'h8ca0;
    a.rd_whole = 16'h0005;
    req(8'h06, 16'h0114, 16'h0032, 0);
    req(8'h06, 16'h0114, 16'h0032, 1);
    // A frame for another slave is ignored and leaves the last cause standing
    p0 = wr_pulses;
    host.xfer({8'h02, 8'h06, 8'h01, 8'h14, 8'h00, 8'h64}, 1'b0, rq);
    check("foreign_len", 16'(rq.size()), 16'h0000);
    check("foreign_cause", 16'(cause_seen), 16'h0006);
    // A broadcast write is carried out without any answer
    host.xfer({8'h00, 8'h06, 8'h01, 8'h14, 8'h00, 8'h64}, 1'b0, rq);
    check("bcast_len", 16'(rq.size()), 16'h0000);
    check("bcast_cause", 16'(cause_seen), 16'h0000);
    check("bcast_pulses", 16'(wr_pulses - p0), 16'h0001);
    check("bcast_whole", wr.whole, 16'h000a);
    req(8'h06, 16'h0114, 16'h0032, 0);
    req(8'h06, 16'h0114, 16'h0032, 2);
    a.max_val = 16'h0002;
    req(8'h06, 16'h0001, 16'h0003, 0);
    a.max_val = 16'h8ca0;
    a.readonly = 1'b1;
    req(8'h06, 16'h0114, 16'h0032, 0);
    a = '{exists: 1'b1, run_locked: 1'b1, decimals: 2'h1, max_val: 16'h8ca0, default: '0};
    running = 1'b1;
    req(8'h06, 16'h0114, 16'h0032, 0);
    fault = 1'b1;
    req(8'h03, 16'h0114, 16'h0001, 0);
    fault = 1'b0;
    req(8'h10, 16'h0114, 16'h0001, 0);
    req(8'h03, 16'h0114, 16'h0000, 0);
    req(8'h03, 16'h0114, 16'h0002, 0);
    pw_set = 1'b1;
    req(8'h03, 16'h0114, 16'h0001, 0);
    req(8'h06, PWD, 16'h1111, 0);
    req(8'h06, PWD, PWDV, 0);
    req(8'h03, 16'h0114, 16'h0001, 0);
    relock();
    req(8'h06, 16'h0114, 16'h0001, 0);
    for (int k = 0; k < 60; k++) begin
      a.exists = $urandom % 8 != 0;
      a.readonly = $urandom % 6 == 0;
      a.run_locked = $urandom % 4 == 0;
      a.conflict = $urandom % 8 == 0;
      a.decimals = 2'($urandom);
      a.min_val = 16'($urandom % 100);
      a.max_val = 16'(100 + $urandom % 900);
      a.rd_whole = 16'($urandom % 60);
      a.rd_frac = 10'($urandom % scl(a.decimals));
      fault = $urandom % 10 == 0;
      running = 1'($urandom);
      pw_set = $urandom % 3 == 0;
      host.slow = 1'($urandom);
      if ($urandom % 8 == 0) relock();
      case ($urandom % 5)
        0: req(8'h03, 16'($urandom), 16'($urandom % 3), 0);
        1: req(8'($urandom), 16'($urandom), 16'($urandom), 0);
        2: req(8'h06, PWD, ($urandom % 2) ? PWDV : 16'($urandom), 0);
        default: req(8'h06, 16'($urandom), 16'($urandom % 1100), ($urandom % 8 == 0) ? 1 : 0);
      endcase
    end
    give_verdict();
  end
endmodule : spexr_responder_test
